// ==== timebase_watchdog_irq_control.sv ====
/*
 Clock source selection, power-down, shared time base / watchdog counter, interrupt pin
 control and 32x4 display memory of a segment display controller.
 Assumes: serial pins and the oscillator pin are asynchronous and are synchronised here;
 an APB3 master on i_sys_clk; the pad resolves the open-drain interrupt pin from o_irq_oe.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module timebase_watchdog_irq_control (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire tbwd_pkg::apb_req_t i_apb,
  output tbwd_pkg::apb_rsp_t o_apb,
  input wire tbwd_pkg::serial_pins_t i_serial,
  input wire logic i_osc_input_pin,
  output logic [127:0] o_seg_data,
  output logic o_bias_on,
  output logic o_sys_clk_run,
  output logic o_irq_o,
  output logic o_irq_oe
);
  import tbwd_pkg::*;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] wr_sync;
    logic [1:0] dat_sync;
    logic [1:0] osc_sync;
    logic wr_prev;
    logic osc_prev;
    ser_st_t ser_st;
    logic [3:0] bit_cnt;
    logic [8:0] shreg;
    logic [5:0] addr;
    logic sys_run;
    logic bias_on;
    logic xtal_ext_drive;
    clk_src_t src;
    logic tb_en;
    logic irq_src_wd;
    logic irq_en;
    logic [2:0] div_n;
    logic [7:0] rc_cnt;
    logic [2:0] pre_cnt;
    logic [6:0] div_cnt;
    logic [7:0] tb;
    logic [1:0] wd_cnt;
    logic wd_flag;
    logic [ram_words-1:0][ram_bits-1:0] ram;
    logic [7:0] last_cmd;
    apb_rsp_t apb;
    logic [127:0] seg;
    logic irq_oe;
    logic irq_o;
    logic clk_run;
  } state_t;

  state_t q_reg;
  state_t q_next;
  logic run_now;
  logic sys_tick;
  logic ref_tick;
  logic wd_tick;
  logic cmd_fire;
  logic ser_fire;
  logic [7:0] ser_code;
  logic wr_rise;
  logic osc_rise;
  logic [6:0] div_mask;
  logic [31:0] rd_data;
  logic mapped;
  status_t status;
  count_t count;

  // Power-down is possible only with RC, or crystal not overdriven externally
  function automatic logic pd_ok(input state_t s);
    return (s.src == src_rc) || (s.src == src_xtal && !s.xtal_ext_drive);
  endfunction : pd_ok

  function automatic state_t exec_cmd(input state_t s, input logic [7:0] c);
    state_t r;
    r = s;
    r.last_cmd = c;
    if (c[7:3] == divider_cmd_head) begin
      r.div_n = c[2:0];
    end else begin
      case (c)
        system_disable_cmd: begin
          if (pd_ok(s)) begin
            r.sys_run = 1'b0;
            r.bias_on = 1'b0;
          end
        end
        system_enable_cmd: r.sys_run = 1'b1;
        display_bias_off_cmd: r.bias_on = 1'b0;
        display_bias_on_cmd: r.bias_on = 1'b1;
        timebase_disable_cmd: r.tb_en = 1'b0;
        watchdog_disable_cmd: r.tb_en = 1'b0;
        timebase_enable_cmd: begin
          r.tb_en = 1'b1;
          r.irq_src_wd = 1'b0;
        end
        watchdog_enable_cmd: begin
          r.tb_en = 1'b1;
          r.irq_src_wd = 1'b1;
        end
        timebase_clear_cmd: r.tb = '0;
        watchdog_clear_cmd: begin
          r.tb = '0;
          r.wd_cnt = '0;
          r.wd_flag = 1'b0;
        end
        src_xtal_cmd: r.src = src_xtal;
        src_rc_cmd: r.src = src_rc;
        src_ext_cmd: r.src = src_ext;
        intr_out_off_cmd: r.irq_en = 1'b0;
        intr_out_on_cmd: r.irq_en = 1'b1;
        default: r.last_cmd = c;
      endcase
    end
    return r;
  endfunction : exec_cmd

  always_comb begin
    q_next = q_reg;
    ser_fire = 1'b0;
    ser_code = q_reg.shreg[7:0];
    cmd_fire = 1'b0;

    // Pin synchronisers
    q_next.cs_sync = {q_reg.cs_sync[0], i_serial.cs_n};
    q_next.wr_sync = {q_reg.wr_sync[0], i_serial.wr_n};
    q_next.dat_sync = {q_reg.dat_sync[0], i_serial.data};
    q_next.osc_sync = {q_reg.osc_sync[0], i_osc_input_pin};
    q_next.wr_prev = q_reg.wr_sync[1];
    q_next.osc_prev = q_reg.osc_sync[1];
    wr_rise = q_reg.wr_sync[1] && !q_reg.wr_prev;
    osc_rise = q_reg.osc_sync[1] && !q_reg.osc_prev;

    // Serial receiver; chip select high restarts framing
    if (q_reg.cs_sync[1]) begin
      q_next.ser_st = ser_id;
      q_next.bit_cnt = '0;
    end else if (wr_rise) begin
      q_next.shreg = {q_reg.shreg[7:0], q_reg.dat_sync[1]};
      q_next.bit_cnt = q_reg.bit_cnt + 4'h1;
      case (q_reg.ser_st)
        ser_id: begin
          if (q_reg.bit_cnt == id_last) begin
            q_next.bit_cnt = '0;
            if ({q_reg.shreg[1:0], q_reg.dat_sync[1]} == cmd_mode_id) begin
              q_next.ser_st = ser_cmd;
            end else if ({q_reg.shreg[1:0], q_reg.dat_sync[1]} == write_mode_id) begin
              q_next.ser_st = ser_addr;
            end else begin
              q_next.ser_st = ser_skip;
            end
          end
        end
        ser_cmd: begin
          if (q_reg.bit_cnt == cmd_last) begin
            q_next.bit_cnt = '0;
            ser_fire = 1'b1;
          end
        end
        ser_addr: begin
          if (q_reg.bit_cnt == addr_last) begin
            q_next.bit_cnt = '0;
            q_next.addr = {q_reg.shreg[4:0], q_reg.dat_sync[1]};
            q_next.ser_st = ser_data;
          end
        end
        ser_data: begin
          // Data nibble arrives least significant bit first
          q_next.shreg = q_reg.shreg;
          q_next.shreg[q_reg.bit_cnt[1:0]] = q_reg.dat_sync[1];
          if (q_reg.bit_cnt == data_last) begin
            q_next.bit_cnt = '0;
            q_next.ram[q_reg.addr[4:0]] = {q_reg.dat_sync[1], q_reg.shreg[2:0]};
            q_next.addr = q_reg.addr + 6'h1;
          end
        end
        default: q_next.bit_cnt = q_reg.bit_cnt;
      endcase
    end
    if (ser_fire) begin
      q_next = exec_cmd(q_next, ser_code);
      cmd_fire = 1'b1;
    end

    // APB slave: one wait state, effect on the edge that samples pready high
    status = '0;
    status.div_n = q_reg.div_n;
    status.wd_flag = q_reg.wd_flag;
    status.irq_en = q_reg.irq_en;
    status.irq_src_wd = q_reg.irq_src_wd;
    status.tb_en = q_reg.tb_en;
    status.src = q_reg.src;
    status.bias_on = q_reg.bias_on;
    status.sys_run = q_reg.sys_run;
    status.clk_run = q_reg.clk_run;
    count = '0;
    count.wd_cnt = q_reg.wd_cnt;
    count.tb = q_reg.tb;
    mapped = (i_apb.paddr[1:0] == 2'b00) && (i_apb.paddr[ram_base_bit]
      || i_apb.paddr == cmd_reg_ofs || i_apb.paddr == cfg_reg_ofs
      || i_apb.paddr == status_reg_ofs || i_apb.paddr == count_reg_ofs);
    rd_data = '0;
    if (i_apb.paddr[ram_base_bit]) begin
      rd_data[ram_bits-1:0] = q_reg.ram[i_apb.paddr[6:2]];
    end else if (i_apb.paddr == cmd_reg_ofs) begin
      rd_data[7:0] = q_reg.last_cmd;
    end else if (i_apb.paddr == cfg_reg_ofs) begin
      rd_data[0] = q_reg.xtal_ext_drive;
    end else if (i_apb.paddr == status_reg_ofs) begin
      rd_data = status;
    end else if (i_apb.paddr == count_reg_ofs) begin
      rd_data = count;
    end
    q_next.apb.pready = i_apb.psel && i_apb.penable && !q_reg.apb.pready;
    q_next.apb.pslverr = 1'b0;
    if (i_apb.psel && i_apb.penable && !q_reg.apb.pready) begin
      q_next.apb.pslverr = !mapped;
      q_next.apb.prdata = mapped ? rd_data : '0;
    end
    if (i_apb.psel && i_apb.penable && q_reg.apb.pready && i_apb.pwrite && mapped) begin
      if (i_apb.paddr[ram_base_bit]) begin
        q_next.ram[i_apb.paddr[6:2]] = i_apb.pwdata[ram_bits-1:0];
      end else if (i_apb.paddr == cmd_reg_ofs) begin
        q_next = exec_cmd(q_next, i_apb.pwdata[7:0]);
        cmd_fire = 1'b1;
      end else if (i_apb.paddr == cfg_reg_ofs) begin
        q_next.xtal_ext_drive = i_apb.pwdata[0];
      end
    end

    // Clock chain: source, prescaler, 2^n divider, time base, watchdog
    run_now = q_reg.sys_run || !pd_ok(q_reg);
    sys_tick = 1'b0;
    ref_tick = 1'b0;
    wd_tick = 1'b0;
    div_mask = ~(div_all_ones << q_reg.div_n);
    if (run_now) begin
      if (q_reg.src == src_rc) begin
        q_next.rc_cnt = (q_reg.rc_cnt == rc_cnt_last) ? 8'h00 : q_reg.rc_cnt + 8'h01;
        sys_tick = (q_reg.rc_cnt == rc_cnt_last);
      end else begin
        sys_tick = osc_rise;
      end
      if (q_reg.src == src_xtal) begin
        ref_tick = sys_tick;
      end else begin
        ref_tick = sys_tick && (q_reg.pre_cnt == prescale_last);
        if (sys_tick) begin
          q_next.pre_cnt = q_reg.pre_cnt + 3'h1;
        end
      end
      if (ref_tick) begin
        q_next.div_cnt = q_reg.div_cnt + 7'h01;
      end
      wd_tick = ref_tick && ((q_reg.div_cnt | ~div_mask) == div_all_ones);
      if (wd_tick && q_reg.tb_en) begin
        q_next.tb = q_next.tb + 8'h01;
        if (q_reg.tb == tb_last) begin
          q_next.wd_cnt = q_next.wd_cnt + 2'h1;
          if (q_reg.wd_cnt == wd_last) begin
            q_next.wd_flag = 1'b1;
          end
        end
      end
    end else begin
      q_next.rc_cnt = '0;
    end

    // Outputs follow the updated state
    q_next.clk_run = q_next.sys_run || !pd_ok(q_next);
    q_next.seg = (q_next.clk_run && q_next.bias_on) ? q_next.ram : '0;
    q_next.irq_o = 1'b0;
    q_next.irq_oe = q_next.clk_run && q_next.irq_en
      && (q_next.irq_src_wd ? q_next.wd_flag : !q_next.tb[7]);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_apb = q_reg.apb;
  assign o_seg_data = q_reg.seg;
  assign o_bias_on = q_reg.bias_on;
  assign o_sys_clk_run = q_reg.clk_run;
  assign o_irq_o = q_reg.irq_o;
  assign o_irq_oe = q_reg.irq_oe;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  sequence apb_setup_s;
    i_apb.psel && !i_apb.penable;
  endsequence

  sequence apb_access_s;
    i_apb.psel && i_apb.penable;
  endsequence

  sequence wd_wrap_s;
    wd_tick && q_reg.tb_en && q_reg.tb == tb_last && q_reg.wd_cnt == wd_last;
  endsequence

  apb_one_wait_a: assert property (apb_setup_s ##1 apb_access_s |-> !o_apb.pready ##1 o_apb.pready)
    else $error("APB answer not after exactly one wait state");

  power_on_state_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    i_reset |=> !o_irq_oe && !o_sys_clk_run && !o_bias_on && q_reg.wd_flag == 1'b0)
    else $error("State after reset is not disabled and cleared");

  wd_flag_set_a: assert property (wd_wrap_s |=> q_reg.wd_flag)
    else $error("Watchdog overflow did not set the time-out flag");

  wd_flag_hold_a: assert property (q_reg.wd_flag && !cmd_fire |=> q_reg.wd_flag)
    else $error("Time-out flag dropped without a command");

  wd_pin_low_a: assert property (q_reg.wd_flag && q_reg.irq_src_wd && q_reg.irq_en
    && q_reg.clk_run |-> o_irq_oe)
    else $error("Interrupt pin not held low after time-out");

  irq_undriven_a: assert property (!q_reg.irq_en |-> !o_irq_oe)
    else $error("Interrupt pin driven while disabled");

  stopped_freeze_a: assert property (!o_sys_clk_run && !cmd_fire
    |=> $stable(q_reg.tb) && $stable(q_reg.wd_cnt) && $stable(q_reg.wd_flag))
    else $error("Counters moved while the system clock is stopped");

  display_blank_a: assert property (!o_sys_clk_run |-> o_seg_data == '0)
    else $error("Display not blank while the system clock is stopped");

  ext_no_stop_a: assert property (q_reg.src == src_ext |-> o_sys_clk_run)
    else $error("External clock source entered power-down");

  prescale_gap_a: assert property (sys_tick && q_reg.src != src_xtal
    && q_reg.pre_cnt != prescale_last |-> !ref_tick)
    else $error("Prescaler passed a tick before eight source ticks");

  div_unity_a: assert property (q_reg.div_n == 3'h0 |-> wd_tick == ref_tick)
    else $error("Divider with n of zero does not pass every reference tick");

endmodule : timebase_watchdog_irq_control

// ==== tbwd_pkg.sv ====
/*
 Shared constants and types for the time base, watchdog and interrupt control block.
 Assumes a single 40 MHz system clock and an APB3 master with 32-bit data.
*/
package tbwd_pkg;

  // System clock and on-chip RC oscillator model
  localparam int sys_clk_hz = 40_000_000;
  localparam int rc_freq_khz = 256;
  localparam int rc_div_cyc = sys_clk_hz / (rc_freq_khz * 1000);
  localparam logic [7:0] rc_cnt_last = 8'(rc_div_cyc - 1);

  // Counter geometry
  localparam logic [2:0] prescale_last = 3'h7;
  localparam logic [7:0] tb_last = 8'hff;
  localparam logic [1:0] wd_last = 2'h3;
  localparam logic [6:0] div_all_ones = 7'h7f;
  localparam int ram_words = 32;
  localparam int ram_bits = 4;

  // Serial framing
  localparam logic [2:0] cmd_mode_id = 3'b100;
  localparam logic [2:0] write_mode_id = 3'b101;
  localparam logic [3:0] id_last = 4'h2;
  localparam logic [3:0] cmd_last = 4'h8;
  localparam logic [3:0] addr_last = 4'h5;
  localparam logic [3:0] data_last = 4'h3;

  // Command codes: eight code bits follow the mode id, then one ignored bit
  localparam logic [7:0] system_disable_cmd = 8'h00;
  localparam logic [7:0] system_enable_cmd = 8'h01;
  localparam logic [7:0] display_bias_off_cmd = 8'h02;
  localparam logic [7:0] display_bias_on_cmd = 8'h03;
  localparam logic [7:0] timebase_disable_cmd = 8'h04;
  localparam logic [7:0] watchdog_disable_cmd = 8'h05;
  localparam logic [7:0] timebase_enable_cmd = 8'h06;
  localparam logic [7:0] watchdog_enable_cmd = 8'h07;
  localparam logic [7:0] timebase_clear_cmd = 8'h0c;
  localparam logic [7:0] watchdog_clear_cmd = 8'h0e;
  localparam logic [7:0] src_xtal_cmd = 8'h14;
  localparam logic [7:0] src_rc_cmd = 8'h18;
  localparam logic [7:0] src_ext_cmd = 8'h1c;
  localparam logic [7:0] intr_out_off_cmd = 8'h80;
  localparam logic [7:0] intr_out_on_cmd = 8'h88;
  localparam logic [4:0] divider_cmd_head = 5'b10100;

  // APB register byte offsets
  localparam logic [7:0] cmd_reg_ofs = 8'h00;
  localparam logic [7:0] cfg_reg_ofs = 8'h04;
  localparam logic [7:0] status_reg_ofs = 8'h08;
  localparam logic [7:0] count_reg_ofs = 8'h0c;
  localparam int ram_base_bit = 7;

  typedef enum logic [1:0] {
    src_rc = 2'b00,
    src_xtal = 2'b01,
    src_ext = 2'b10
  } clk_src_t;

  typedef enum logic [2:0] {
    ser_id = 3'b000,
    ser_cmd = 3'b001,
    ser_addr = 3'b010,
    ser_data = 3'b011,
    ser_skip = 3'b100
  } ser_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic data;
  } serial_pins_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [2:0] div_n;
    logic wd_flag;
    logic irq_en;
    logic irq_src_wd;
    logic tb_en;
    clk_src_t src;
    logic bias_on;
    logic sys_run;
    logic clk_run;
  } status_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic [1:0] wd_cnt;
    logic [7:0] tb;
  } count_t;

endpackage : tbwd_pkg

// ==== tbwd_host.sv ====
/*
 Host model that drives the three-wire serial command link of the block.
 Assumes the bench calls send_cmds hierarchically and that released lines are pulled high.
*/
`timescale 1ns/100ps
module tbwd_host #(
  parameter int half_cyc = 68
) (
  input wire logic i_sys_clk,
  output tbwd_pkg::serial_pins_t o_serial
);
  import tbwd_pkg::*;

  initial o_serial = '1;

  task wr_bit(input logic b);
    @(posedge i_sys_clk);
    o_serial.wr_n <= 1'b0;
    o_serial.data <= b;
    repeat (half_cyc) @(posedge i_sys_clk);
    o_serial.wr_n <= 1'b1;
    repeat (half_cyc) @(posedge i_sys_clk);
  endtask : wr_bit

  // Sends the mode id, then one or two commands from the high byte down
  task send_cmds(input logic [15:0] codes, input int count);
    logic [7:0] c;
    @(posedge i_sys_clk);
    o_serial.cs_n <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    for (int i = 2; i >= 0; i--) wr_bit(cmd_mode_id[i]);
    for (int j = 0; j < count; j++) begin
      c = (j == 0) ? codes[15:8] : codes[7:0];
      for (int i = 7; i >= 0; i--) wr_bit(c[i]);
      wr_bit(1'b0);
    end
    o_serial <= '1;
    repeat (20) @(posedge i_sys_clk);
  endtask : send_cmds

  // Data mode: write id, address A5 first, then one nibble D0 first
  task send_data(input logic [5:0] a, input logic [3:0] d);
    @(posedge i_sys_clk);
    o_serial.cs_n <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    for (int i = 2; i >= 0; i--) wr_bit(write_mode_id[i]);
    for (int i = 5; i >= 0; i--) wr_bit(a[i]);
    for (int i = 0; i < 4; i++) wr_bit(d[i]);
    o_serial <= '1;
    repeat (20) @(posedge i_sys_clk);
  endtask : send_data
endmodule : tbwd_host

// ==== timebase_watchdog_irq_control_bench.sv ====
/*
 Self-checking bench for the time base, watchdog and interrupt control block.
 Assumes the APB slave answers with one wait state and the host model for the serial link.
*/
`timescale 1ns/100ps
module timebase_watchdog_irq_control_bench;
  import tbwd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic osc = 1'b0;
  apb_req_t apb_q = '0;
  apb_rsp_t apb_r;
  serial_pins_t ser;
  logic [127:0] seg;
  logic bias_on, clk_run, irq_o, irq_oe;
  int bad_count = 0;
  int samples_checked = 0;
  integer seed = 32'h7f1c51b3;
  logic [31:0] rd;
  logic err;
  logic [127:0] seg_exp = '0;
  logic [3:0] nib;
  int k;

  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  timebase_watchdog_irq_control dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_apb(apb_q),
    .o_apb(apb_r), .i_serial(ser), .i_osc_input_pin(osc), .o_seg_data(seg),
    .o_bias_on(bias_on), .o_sys_clk_run(clk_run), .o_irq_o(irq_o), .o_irq_oe(irq_oe));
  tbwd_host host (.i_sys_clk(i_sys_clk), .o_serial(ser));

  function automatic logic [31:0] st_exp(input logic run, sys, bias, input logic [1:0] src,
      input logic tb, wds, ien, wdf, input logic [2:0] n);
    return {20'h0, n, wdf, ien, wds, tb, src, bias, sys, run};
  endfunction : st_exp

  task close_out;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_sys_clk);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (apb_r.pready !== 1'b1 && n < 50);
    rd = apb_r.prdata;
    err = apb_r.pslverr;
    apb_q <= '0;
    if (n >= 50) begin
      chk("pready", 1, 0);
      close_out;
    end
  endtask : apb

  task cmd(input logic [7:0] c);
    apb(1'b1, cmd_reg_ofs, {24'h0, c});
    repeat (2) @(posedge i_sys_clk);
  endtask : cmd

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task pulses(input int n);
    repeat (n) begin
      @(posedge i_sys_clk) osc <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      osc <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
    end
    repeat (8) @(posedge i_sys_clk);
  endtask : pulses

  initial begin
    repeat (60000) @(posedge i_sys_clk);
    bad_count++;
    $display("ERROR run time expected end seen hang");
    close_out;
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    chk("reset outputs", 0, {bias_on, clk_run, irq_o, irq_oe});
    rdchk("reset status", status_reg_ofs, st_exp(0, 0, 0, 0, 0, 0, 0, 0, 0));
    apb(1'b1, status_reg_ofs, 32'hffff_ffff);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {err, rd});
    rdchk("status kept", status_reg_ofs, 32'h0);
    host.send_cmds({system_enable_cmd, display_bias_on_cmd}, 2);
    repeat (8) @(posedge i_sys_clk);
    chk("run bias", 2'b11, {clk_run, bias_on});
    for (int i = 0; i < 32; i++) begin
      nib = 4'($random(seed));
      apb(1'b1, 8'h80 + 8'(4 * i), {28'h0, nib});
      seg_exp[4 * i +: 4] = nib;
    end
    repeat (2) @(posedge i_sys_clk);
    chk("seg image", seg_exp, seg);
    k = $random(seed) & 31;
    apb(1'b0, 8'h80 + 8'(4 * k), 32'h0);
    apb(1'b1, 8'h80 + 8'(4 * k), {28'h0, ~rd[3:0]});
    seg_exp[4 * k +: 4] = ~seg_exp[4 * k +: 4];
    repeat (2) @(posedge i_sys_clk);
    chk("seg rmw", seg_exp, seg);
    k = $random(seed) & 31;
    nib = 4'($random(seed));
    host.send_data(6'(k), nib);
    seg_exp[4 * k +: 4] = nib;
    repeat (8) @(posedge i_sys_clk);
    chk("seg serial", seg_exp, seg);
    cmd(src_xtal_cmd);
    cmd(timebase_clear_cmd);
    cmd(timebase_enable_cmd);
    k = 1 + ($random(seed) & 63);
    pulses(k);
    rdchk("count", count_reg_ofs, 32'(k));
    cmd(timebase_clear_cmd);
    rdchk("count clear", count_reg_ofs, 32'h0);
    cmd({divider_cmd_head, 3'd3});
    pulses(80);
    rdchk("count div8", count_reg_ofs, 32'd10);
    cmd({divider_cmd_head, 3'd0});
    cmd(src_ext_cmd);
    cmd(timebase_clear_cmd);
    pulses(64);
    rdchk("prescaled", count_reg_ofs, 32'd8);
    cmd(src_xtal_cmd);
    cmd(watchdog_clear_cmd);
    cmd(watchdog_enable_cmd);
    cmd(intr_out_on_cmd);
    rdchk("wd status", status_reg_ofs, st_exp(1, 1, 1, src_xtal, 1, 1, 1, 0, 0));
    pulses(1023);
    chk("oe early", 0, irq_oe);
    pulses(1);
    chk("oe timeout", 1, irq_oe);
    pulses(5);
    chk("oe hold", 2'b01, {irq_o, irq_oe});
    cmd(intr_out_off_cmd);
    chk("oe off", 0, irq_oe);
    cmd(intr_out_on_cmd);
    chk("oe again", 1, irq_oe);
    cmd(watchdog_clear_cmd);
    chk("oe cleared", 0, irq_oe);
    cmd(timebase_clear_cmd);
    cmd(timebase_enable_cmd);
    chk("timer low", 1, irq_oe);
    pulses(128);
    chk("timer bit7", 0, irq_oe);
    cmd(watchdog_disable_cmd);
    pulses(10);
    rdchk("count stop", count_reg_ofs, 32'h80);
    cmd(src_ext_cmd);
    host.send_cmds({system_disable_cmd, 8'h00}, 1);
    repeat (8) @(posedge i_sys_clk);
    chk("ext run", 2'b11, {clk_run, bias_on});
    cmd(src_xtal_cmd);
    apb(1'b1, cfg_reg_ofs, 32'h1);
    cmd(system_disable_cmd);
    chk("xtal pin run", 2'b11, {clk_run, bias_on});
    apb(1'b1, cfg_reg_ofs, 32'h0);
    cmd(timebase_enable_cmd);
    cmd(system_disable_cmd);
    chk("stopped", 0, {clk_run, bias_on, irq_oe, seg});
    pulses(10);
    rdchk("count frozen", count_reg_ofs, 32'h80);
    cmd(system_enable_cmd);
    cmd(display_bias_on_cmd);
    cmd(src_rc_cmd);
    cmd(timebase_disable_cmd);
    rdchk("rc status", status_reg_ofs, st_exp(1, 1, 1, src_rc, 0, 0, 1, 0, 0));
    cmd(display_bias_off_cmd);
    chk("bias off", 2'b10, {clk_run, bias_on});
    cmd(system_disable_cmd);
    chk("power down", 0, {clk_run, bias_on});
    close_out;
  end
endmodule : timebase_watchdog_irq_control_bench
